// [afdpm_pkg.sv]
// Constants, register map and types shared by the level monitor
package afdpm_pkg;
  localparam int NCH = 4;
  localparam int SW = 8;
  localparam int MW = 13;
  localparam int LW = NCH * SW;
  localparam int FIFO_DEPTH = 32;
  localparam int FRAME_W = 25;
  localparam int SUB_N = 5;
  localparam int SUB_DATA = 4;
  localparam int FD_MAX_LAT_CYC = 30;

  // Serial control port register addresses
  localparam logic [14:0] ADDR_FD_FLAGS = 15'h0040;
  localparam logic [14:0] ADDR_UP_LO = 15'h0247;
  localparam logic [14:0] ADDR_UP_HI = 15'h0248;
  localparam logic [14:0] ADDR_LO_LO = 15'h0249;
  localparam logic [14:0] ADDR_LO_HI = 15'h024a;
  localparam logic [14:0] ADDR_DW_LO = 15'h024b;
  localparam logic [14:0] ADDR_DW_HI = 15'h024c;
  localparam logic [14:0] ADDR_MON_CTRL = 15'h0270;
  localparam logic [14:0] ADDR_PER_B0 = 15'h0271;
  localparam logic [14:0] ADDR_PER_B1 = 15'h0272;
  localparam logic [14:0] ADDR_PER_B2 = 15'h0273;
  localparam logic [14:0] ADDR_PEAK_LO = 15'h0274;
  localparam logic [14:0] ADDR_PEAK_HI = 15'h0275;
  localparam logic [14:0] ADDR_LINK_EN_A = 15'h0279;
  localparam logic [14:0] ADDR_LINK_EN_B = 15'h027a;
  localparam logic [14:0] ADDR_CTRL_BITS = 15'h0280;

  // Field positions
  localparam int MON_EN_BIT = 1;
  localparam int MON_SEL_LSB = 4;
  localparam int LINK_EN_A_BIT = 0;
  localparam int LINK_EN_B_BIT = 1;
  localparam int CB_MON_TOP_BIT = 2;

  // Reset values
  localparam logic [MW-1:0] UP_THR_RST = 13'h1fff;
  localparam logic [MW-1:0] LO_THR_RST = 13'h0000;
  localparam logic [15:0] DWELL_RST = 16'h0001;
  localparam logic [23:0] PERIOD_RST = 24'h00_0080;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // Serial control port framing
  localparam logic [4:0] SPI_CMD_LAST = 5'h0f;
  localparam logic [4:0] SPI_DATA_LAST = 5'h07;

  typedef enum logic [1:0] {
    SP_IDLE = 2'b00,
    SP_ADDR = 2'b01,
    SP_DATA = 2'b11,
    SP_DONE = 2'b10
  } afdpm_spi_t;
endpackage

// [afdpm_fifo.sv]
// Flop-based FIFO in the link sample path
`timescale 1ns/1ps
module afdpm_fifo #(
  parameter int W = 32,
  parameter int D = 32
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [W-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [W-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0] wrPtrQ;
  logic [AW:0] rdPtrQ;
  wire logic push = inValid && inReady;
  wire logic pop = outValid && outReady;
  wire logic full = (wrPtrQ[AW] != rdPtrQ[AW]) && (wrPtrQ[AW-1:0] == rdPtrQ[AW-1:0]);
  wire logic empty = wrPtrQ == rdPtrQ;

  assign inReady = !full;
  assign outValid = !empty;
  assign outData = mem[rdPtrQ[AW-1:0]];

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wrPtrQ[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wrPtrQ <= '0;
      rdPtrQ <= '0;
    end else begin
      if (push) begin
        wrPtrQ <= wrPtrQ + 1'b1;
      end
      if (pop) begin
        rdPtrQ <= rdPtrQ + 1'b1;
      end
    end
  end
endmodule

// [afdpm_monitor.sv]
// Fast detect, overrange, peak monitor and control-bit insertion
//
// Function
// - Overrange indicator follows the input with the same latency as its sample.
// - With control bits enabled, overrange can ride as a link control bit.
// - Four independent fast-detect circuits, one output pin per channel.
// - Fast-detect flag sets at once when magnitude exceeds upper threshold.
// - Flag clears only after magnitude stays below lower threshold beyond dwell.
// - Upper threshold comes from its register pair, compared with magnitude.
// - Flag asserts within 30 clocks of crossing the upper threshold.
// - Lower threshold is 13 bits, compared at full resolution.
// - Dwell time programmable 1 to 65535 sample clocks via register pair.
// - Peak detector tracks magnitude only, result 13 bits wide.
// - Measurement period is a global 24-bit count of output samples.
// - On enable the period loads a countdown timer ticking per sample.
// - Store seeds with current magnitude, then keeps the larger value.
// - At count 1 copy peak to holding, reload timer, reseed store.
// - Up to three control bits per sample, filled from the top position.
// - Peak sent as 25-bit frame, MSB first, five subframes with start bits.
`timescale 1ns/1ps
module afdpm_monitor
  import afdpm_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [NCH-1:0][SW-1:0] sampleIn,
  input wire logic [NCH-1:0] overrangeIn,
  input wire logic sampleValid,
  output logic sampleReady,
  output logic [NCH-1:0] overrangeOut,
  output logic fastDetectOutCh0,
  output logic fastDetectOutCh1,
  output logic fastDetectOutCh2,
  output logic fastDetectOutCh3,
  output logic [LW-1:0] linkData,
  output logic linkValid,
  input wire logic linkReady,
  input wire logic spiCsN,
  input wire logic spiSclk,
  input wire logic spiSdi,
  output logic spiSdo,
  output logic spiSdoOe
);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [MW-1:0] mag13(input logic [SW-1:0] s);
    logic [SW-1:0] a;
    a = s[SW-1] ? SW'(~s + 1'b1) : s;
    return {a, {(MW - SW){1'b0}}};
  endfunction

  function automatic logic [MW-1:0] max13(input logic [MW-1:0] a, input logic [MW-1:0] b);
    return (a > b) ? a : b;
  endfunction

  function automatic logic [FRAME_W-1:0] buildFrame(input logic [MW-1:0] p);
    logic [SUB_N*SUB_DATA-1:0] d;
    logic [FRAME_W-1:0] f;
    d = {{(SUB_N * SUB_DATA - MW){1'b0}}, p};
    f = '0;
    for (int i = 0; i < SUB_N; i++) begin
      f[FRAME_W-1-i*(SUB_DATA+1) -: SUB_DATA+1] =
        {1'b1, d[SUB_N*SUB_DATA-1-i*SUB_DATA -: SUB_DATA]};
    end
    return f;
  endfunction

  function automatic logic [SW-1:0] packWord(input logic [SW-1:0] s, input logic [1:0] cs,
                                             input logic [2:0] cb);
    case (cs)
      2'd0: packWord = s;
      2'd1: packWord = {s[SW-1:1], cb[2]};
      2'd2: packWord = {s[SW-1:2], cb[2:1]};
      default: packWord = {s[SW-1:3], cb};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [MW-1:0] upThrQ;
  logic [MW-1:0] loThrQ;
  logic [15:0] dwellQ;
  logic [7:0] monCtrlQ;
  logic [23:0] periodQ;
  logic [7:0] linkEnAQ;
  logic [7:0] linkEnBQ;
  logic [7:0] ctrlBitsQ;
  logic [MW-1:0] holdQ;
  logic fdQ [NCH];
  logic [NCH-1:0] fdVec;
  logic [7:0] rdMux;

  // Serial control port
  afdpm_spi_t spiStQ;
  logic [4:0] bitCntQ;
  logic [23:0] shQ;
  logic rwQ;
  logic [14:0] addrQ;
  logic [7:0] rdShQ;
  logic sclkQ;
  logic sdoQ;
  logic oeQ;

  wire logic sclkRise = spiSclk && !sclkQ;
  wire logic sclkFall = !spiSclk && sclkQ;
  wire logic [14:0] addrNow = {shQ[13:0], spiSdi};
  wire logic [7:0] wrData = {shQ[6:0], spiSdi};
  wire logic wrEn = (spiStQ == SP_DATA) && sclkRise && (bitCntQ == SPI_DATA_LAST) && !rwQ;
  wire logic cmdDone = (spiStQ == SP_ADDR) && sclkRise && (bitCntQ == SPI_CMD_LAST);

  assign spiSdo = sdoQ;
  assign spiSdoOe = oeQ;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sclkQ <= 1'b0;
    end else begin
      sclkQ <= spiSclk;
    end
  end

  // No streaming: one address, one byte per chip-select frame
  always_ff @(posedge clock) begin
    if (sys_rst || spiCsN) begin
      spiStQ <= SP_IDLE;
      bitCntQ <= '0;
      shQ <= '0;
      rwQ <= 1'b0;
      addrQ <= '0;
      rdShQ <= '0;
      sdoQ <= 1'b0;
      oeQ <= 1'b0;
    end else begin
      if (sclkRise) begin
        shQ <= {shQ[22:0], spiSdi};
        bitCntQ <= bitCntQ + 5'd1;
      end
      case (spiStQ)
        SP_IDLE: spiStQ <= SP_ADDR;
        SP_ADDR: begin
          if (cmdDone) begin
            rwQ <= shQ[14];
            addrQ <= addrNow;
            rdShQ <= rdMux;
            bitCntQ <= '0;
            spiStQ <= SP_DATA;
          end
        end
        SP_DATA: begin
          if (sclkFall && rwQ) begin
            sdoQ <= rdShQ[7];
            rdShQ <= {rdShQ[6:0], 1'b0};
            oeQ <= 1'b1;
          end
          if (sclkRise && bitCntQ == SPI_DATA_LAST) begin
            spiStQ <= SP_DONE;
          end
        end
        SP_DONE: spiStQ <= SP_DONE;
        default: spiStQ <= SP_IDLE;
      endcase
    end
  end

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      fdVec[c] = fdQ[c];
    end
  end

  // Read answers from the address just shifted in
  always_comb begin
    case (addrNow)
      ADDR_FD_FLAGS: rdMux = {4'h0, fdVec};
      ADDR_UP_LO: rdMux = upThrQ[7:0];
      ADDR_UP_HI: rdMux = {3'h0, upThrQ[12:8]};
      ADDR_LO_LO: rdMux = loThrQ[7:0];
      ADDR_LO_HI: rdMux = {3'h0, loThrQ[12:8]};
      ADDR_DW_LO: rdMux = dwellQ[7:0];
      ADDR_DW_HI: rdMux = dwellQ[15:8];
      ADDR_MON_CTRL: rdMux = monCtrlQ;
      ADDR_PER_B0: rdMux = periodQ[7:0];
      ADDR_PER_B1: rdMux = periodQ[15:8];
      ADDR_PER_B2: rdMux = periodQ[23:16];
      ADDR_PEAK_LO: rdMux = holdQ[7:0];
      ADDR_PEAK_HI: rdMux = {3'h0, holdQ[12:8]};
      ADDR_LINK_EN_A: rdMux = linkEnAQ;
      ADDR_LINK_EN_B: rdMux = linkEnBQ;
      ADDR_CTRL_BITS: rdMux = ctrlBitsQ;
      default: rdMux = 8'h00;
    endcase
  end

  // Flag register ignores writes; its flags are hardware state
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      upThrQ <= UP_THR_RST;
      loThrQ <= LO_THR_RST;
      dwellQ <= DWELL_RST;
      monCtrlQ <= BYTE_RST;
      periodQ <= PERIOD_RST;
      linkEnAQ <= BYTE_RST;
      linkEnBQ <= BYTE_RST;
      ctrlBitsQ <= BYTE_RST;
    end else if (wrEn) begin
      case (addrQ)
        ADDR_UP_LO: upThrQ[7:0] <= wrData;
        ADDR_UP_HI: upThrQ[12:8] <= wrData[4:0];
        ADDR_LO_LO: loThrQ[7:0] <= wrData;
        ADDR_LO_HI: loThrQ[12:8] <= wrData[4:0];
        ADDR_DW_LO: dwellQ[7:0] <= wrData;
        ADDR_DW_HI: dwellQ[15:8] <= wrData;
        ADDR_MON_CTRL: monCtrlQ <= wrData;
        ADDR_PER_B0: periodQ[7:0] <= wrData;
        ADDR_PER_B1: periodQ[15:8] <= wrData;
        ADDR_PER_B2: periodQ[23:16] <= wrData;
        ADDR_LINK_EN_A: linkEnAQ <= wrData;
        ADDR_LINK_EN_B: linkEnBQ <= wrData;
        ADDR_CTRL_BITS: ctrlBitsQ <= wrData;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample intake; a full FIFO stalls the converter stream
  logic fifoInReady;
  wire logic take = sampleValid && fifoInReady;
  assign sampleReady = fifoInReady;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      overrangeOut <= '0;
    end else if (take) begin
      overrangeOut <= overrangeIn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fast detect, one per channel; one-clock latency, well inside 30
  for (genvar c = 0; c < NCH; c++) begin : g_fd
    logic [15:0] dwCntQ;
    wire logic [MW-1:0] chMag = mag13(sampleIn[c]);
    wire logic above = chMag > upThrQ;
    wire logic below = chMag < loThrQ;
    always_ff @(posedge clock) begin
      if (sys_rst) begin
        fdQ[c] <= 1'b0;
        dwCntQ <= '0;
      end else if (take) begin
        if (above) begin
          fdQ[c] <= 1'b1;
          dwCntQ <= '0;
        end else if (below) begin
          if (fdQ[c] && dwCntQ >= dwellQ) begin
            fdQ[c] <= 1'b0;
            dwCntQ <= '0;
          end else if (dwCntQ != 16'hffff) begin
            dwCntQ <= dwCntQ + 16'd1;
          end
        end else begin
          dwCntQ <= '0;
        end
      end
    end
  end

  assign fastDetectOutCh0 = fdQ[0];
  assign fastDetectOutCh1 = fdQ[1];
  assign fastDetectOutCh2 = fdQ[2];
  assign fastDetectOutCh3 = fdQ[3];

  ////////////////////////////////////////////////////////////////////////////
  // Peak monitor on the selected channel
  logic runQ;
  logic seedQ;
  logic [23:0] timerQ;
  logic [MW-1:0] peakQ;
  wire logic monEn = monCtrlQ[MON_EN_BIT];
  wire logic [1:0] monSel = monCtrlQ[MON_SEL_LSB +: 2];
  wire logic [MW-1:0] monMag = mag13(sampleIn[monSel]);
  wire logic [MW-1:0] curPeak = seedQ ? monMag : max13(peakQ, monMag);
  wire logic xfer = runQ && monEn && take && (timerQ <= 24'd1);

  // Period of 0 behaves as 1 rather than wrapping to a huge count
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      runQ <= 1'b0;
      seedQ <= 1'b1;
      timerQ <= '0;
      peakQ <= '0;
      holdQ <= '0;
    end else if (!monEn) begin
      runQ <= 1'b0;
    end else if (!runQ) begin
      runQ <= 1'b1;
      timerQ <= periodQ;
      seedQ <= 1'b1;
    end else if (take) begin
      peakQ <= curPeak;
      if (timerQ <= 24'd1) begin
        holdQ <= curPeak;
        timerQ <= periodQ;
        seedQ <= 1'b1;
      end else begin
        timerQ <= timerQ - 24'd1;
        seedQ <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame serializer, one bit per accepted sample
  logic [FRAME_W-1:0] frameQ;
  logic [4:0] bitsLeftQ;
  wire logic linkMonOn = linkEnAQ[LINK_EN_A_BIT] && linkEnBQ[LINK_EN_B_BIT];
  wire logic monBit = (bitsLeftQ != 5'd0) && frameQ[FRAME_W-1];

  // A new result restarts the frame; keep the period at 25 or more
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      frameQ <= '0;
      bitsLeftQ <= '0;
    end else if (take) begin
      if (xfer && linkMonOn) begin
        frameQ <= buildFrame(curPeak);
        bitsLeftQ <= 5'(FRAME_W);
      end else if (bitsLeftQ != 5'd0) begin
        frameQ <= {frameQ[FRAME_W-2:0], 1'b0};
        bitsLeftQ <= bitsLeftQ - 5'd1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control-bit insertion; the control bits replace low sample bits
  logic [LW-1:0] linkWord;
  wire logic [1:0] csCnt = ctrlBitsQ[1:0];
  wire logic monTop = ctrlBitsQ[CB_MON_TOP_BIT] && linkMonOn;

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      linkWord[c*SW +: SW] = packWord(sampleIn[c], csCnt,
        {monTop ? monBit : overrangeIn[c], fdQ[c], overrangeIn[c]});
    end
  end

  afdpm_fifo #(
    .W(LW),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .sys_rst(sys_rst),
    .inData(linkWord),
    .inValid(sampleValid),
    .inReady(fifoInReady),
    .outData(linkData),
    .outValid(linkValid),
    .outReady(linkReady)
  );
endmodule

// [afdpm_monitor_asserts.sv]
// Port-level assertions for the level monitor
`timescale 1ns/1ps
module afdpm_monitor_asserts
  import afdpm_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [NCH-1:0] overrangeIn,
  input wire logic sampleValid,
  input wire logic sampleReady,
  input wire logic [NCH-1:0] overrangeOut,
  input wire logic fastDetectOutCh0,
  input wire logic fastDetectOutCh1,
  input wire logic fastDetectOutCh2,
  input wire logic fastDetectOutCh3,
  input wire logic [LW-1:0] linkData,
  input wire logic linkValid,
  input wire logic linkReady,
  input wire logic spiCsN,
  input wire logic spiSclk,
  input wire logic spiSdo,
  input wire logic spiSdoOe
);
  wire [3:0] fdAll = {fastDetectOutCh3, fastDetectOutCh2, fastDetectOutCh1, fastDetectOutCh0};
  wire noTake = !(sampleValid && sampleReady);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////
  sequence s_take;
    sampleValid && sampleReady;
  endsequence
  sequence s_csIdle;
    spiCsN ##1 spiCsN;
  endsequence
  property p_ovr;
    s_take |=> overrangeOut == $past(overrangeIn);
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrange not aligned");
  property p_ovrHold;
    noTake |=> $stable(overrangeOut);
  endproperty
  a_ovrHold: assert property (p_ovrHold) else $error("overrange moved");
  property p_fdHold;
    noTake |=> $stable(fdAll);
  endproperty
  a_fdHold: assert property (p_fdHold) else $error("flag moved without sample");
  property p_fill;
    s_take |=> linkValid;
  endproperty
  a_fill: assert property (p_fill) else $error("taken sample not queued");
  property p_linkHold;
    linkValid && !linkReady |=> linkValid && $stable(linkData);
  endproperty
  a_linkHold: assert property (p_linkHold) else $error("link word dropped");
  property p_oeOff;
    s_csIdle |=> !spiSdoOe;
  endproperty
  a_oeOff: assert property (p_oeOff) else $error("readback drive while idle");
  property p_oeRise;
    $rose(spiSdoOe) |-> $past(spiSclk, 2) && !$past(spiSclk) && !spiCsN;
  endproperty
  a_oeRise: assert property (p_oeRise) else $error("drive not at falling edge");
  property p_sdoEdge;
    $changed(spiSdo) |-> ($past(spiSclk, 2) && !$past(spiSclk)) || $past(spiCsN) || spiCsN;
  endproperty
  a_sdoEdge: assert property (p_sdoEdge) else $error("readback bit off edge");
endmodule
bind afdpm_monitor afdpm_monitor_asserts afdpm_monitor_asserts_inst (.clock(clock),
  .sys_rst(sys_rst), .overrangeIn(overrangeIn), .sampleValid(sampleValid),
  .sampleReady(sampleReady), .overrangeOut(overrangeOut), .fastDetectOutCh0(fastDetectOutCh0),
  .fastDetectOutCh1(fastDetectOutCh1), .fastDetectOutCh2(fastDetectOutCh2),
  .fastDetectOutCh3(fastDetectOutCh3), .linkData(linkData), .linkValid(linkValid),
  .linkReady(linkReady), .spiCsN(spiCsN), .spiSclk(spiSclk), .spiSdo(spiSdo),
  .spiSdoOe(spiSdoOe));

// [afdpm_link_rx.sv]
// Downstream receiver model that rebuilds the monitor frame
`timescale 1ns/1ps
module afdpm_link_rx
  import afdpm_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [LW-1:0] linkData,
  input wire logic linkValid,
  input wire logic stall,
  output logic linkReady,
  output logic [FRAME_W-1:0] frame,
  output logic frameOk,
  output int nWords
);
  logic [FRAME_W-2:0] sr;
  int cnt;
  wire [FRAME_W-1:0] nextFrame = {sr, linkData[0]};
  wire startsOk = nextFrame[24] & nextFrame[19] & nextFrame[14] & nextFrame[9] & nextFrame[4];
  ////////////////////////////////////////////////////////////
  // Idle bits are 0, so the first 1 is a start bit
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      linkReady <= 1'b0;
      sr <= '0;
      cnt <= 0;
      nWords <= 0;
      frame <= '0;
      frameOk <= 1'b0;
    end else begin
      linkReady <= !stall;
      if (linkValid && linkReady) begin
        nWords <= nWords + 1;
        if (cnt != 0 || linkData[0]) begin
          sr <= nextFrame[FRAME_W-2:0];
          cnt <= (cnt == FRAME_W - 1) ? 0 : cnt + 1;
        end
        if (cnt == FRAME_W - 1) begin
          frame <= nextFrame;
          frameOk <= startsOk;
        end
      end
    end
  end
endmodule

// [afdpm_monitor_tb.sv]
// Self-checking bench for the level monitor
`timescale 1ns/1ps
module afdpm_monitor_tb;
  import afdpm_pkg::*;
  logic clock, sys_rst, sampleValid, spiCsN, spiSclk, spiSdi, stall, frameOk;
  logic [NCH-1:0][SW-1:0] sampleIn;
  logic [NCH-1:0] overrangeIn, overrangeOut;
  logic sampleReady, linkValid, linkReady, spiSdo, spiSdoOe;
  wire [3:0] fd;
  logic [LW-1:0] linkData;
  logic [FRAME_W-1:0] frame;
  logic [7:0] rd;
  int nWords, nSent, nMismatch, checked;
  afdpm_monitor afdpm_monitor_inst (.clock(clock), .sys_rst(sys_rst), .sampleIn(sampleIn),
    .overrangeIn(overrangeIn), .sampleValid(sampleValid), .sampleReady(sampleReady),
    .overrangeOut(overrangeOut), .fastDetectOutCh0(fd[0]), .fastDetectOutCh1(fd[1]),
    .fastDetectOutCh2(fd[2]), .fastDetectOutCh3(fd[3]), .linkData(linkData),
    .linkValid(linkValid), .linkReady(linkReady), .spiCsN(spiCsN), .spiSclk(spiSclk),
    .spiSdi(spiSdi), .spiSdo(spiSdo), .spiSdoOe(spiSdoOe));
  afdpm_link_rx afdpm_link_rx_inst (.clock(clock), .sys_rst(sys_rst), .linkData(linkData),
    .linkValid(linkValid), .stall(stall), .linkReady(linkReady), .frame(frame),
    .frameOk(frameOk), .nWords(nWords));
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      nMismatch++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d, mismatches %0d", checked, nMismatch);
    if (nMismatch == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n >= 500) begin
      nMismatch++;
      results();
    end
  endtask
  // Each sclk level held 3 clocks, above the 2-clock minimum
  task automatic spi(input logic r, input logic [14:0] a, input logic [7:0] d);
    logic [23:0] w;
    w = {r, a, d};
    @(posedge clock);
    spiCsN <= 1'b0;
    repeat (2) @(posedge clock);
    for (int i = 0; i < 24; i++) begin
      spiSclk <= 1'b0;
      spiSdi <= w[23-i];
      repeat (3) @(posedge clock);
      if (i >= 16) rd[23-i] = spiSdo;
      if (i == 23) chk(spiSdoOe, r);
      spiSclk <= 1'b1;
      repeat (3) @(posedge clock);
    end
    spiCsN <= 1'b1;
    repeat (2) @(posedge clock);
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    spi(1'b0, a, d);
  endtask
  task automatic rdc(input logic [14:0] a, input logic [7:0] e);
    spi(1'b1, a, 8'h00);
    chk(rd, e);
  endtask
  task automatic put(input logic [31:0] s, input logic [3:0] o);
    int n;
    n = 0;
    @(posedge clock);
    sampleIn <= s;
    overrangeIn <= o;
    sampleValid <= 1'b1;
    @(negedge clock);
    while (sampleReady !== 1'b1 && n < 500) begin
      n++;
      @(negedge clock);
    end
    tmo(n);
    @(posedge clock);
    sampleValid <= 1'b0;
    nSent++;
    @(negedge clock);
    chk(overrangeOut, o);
  endtask
  task automatic drain();
    int n;
    n = 0;
    while (linkValid !== 1'b0 && n < 500) begin
      n++;
      @(negedge clock);
    end
    tmo(n);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic scRegs();
    rdc(ADDR_UP_LO, 8'hff);
    rdc(ADDR_UP_HI, 8'h1f);
    rdc(ADDR_LO_HI, 8'h00);
    rdc(ADDR_DW_LO, 8'h01);
    rdc(ADDR_PER_B0, 8'h80);
    rdc(15'h0100, 8'h00);
  endtask
  // Upper 2048, lower 512, dwell 3
  task automatic scFast();
    wr(ADDR_UP_LO, 8'h00);
    wr(ADDR_UP_HI, 8'h08);
    wr(ADDR_LO_LO, 8'h00);
    wr(ADDR_LO_HI, 8'h02);
    wr(ADDR_DW_LO, 8'h03);
    wr(ADDR_DW_HI, 8'h00);
    rdc(ADDR_UP_HI, 8'h08);
    rdc(ADDR_DW_LO, 8'h03);
    put(32'h0000_0040, 4'h0);
    chk(fd, 4'h0);
    put(32'h0000_8050, 4'h5);
    chk(fd, 4'h3);
    rdc(ADDR_FD_FLAGS, 8'h03);
    repeat (2) put(32'h0000_0000, 4'h0);
    put(32'h0000_1010, 4'h0);
    repeat (3) put(32'h0000_0000, 4'h0);
    chk(fd, 4'h3);
    put(32'h0000_0000, 4'h0);
    chk(fd, 4'h0);
  endtask
  task automatic scPeak();
    wr(ADDR_PER_B0, 8'h04);
    wr(ADDR_PER_B1, 8'h00);
    wr(ADDR_PER_B2, 8'h00);
    wr(ADDR_MON_CTRL, 8'h02);
    put(32'h0000_000a, 4'h0);
    put(32'h0000_00c4, 4'h0);
    put(32'h0000_0014, 4'h0);
    put(32'h0000_0006, 4'h0);
    rdc(ADDR_PEAK_LO, 8'h80);
    rdc(ADDR_PEAK_HI, 8'h07);
    repeat (4) put(32'h0000_0002, 4'h0);
    rdc(ADDR_PEAK_LO, 8'h40);
    rdc(ADDR_PEAK_HI, 8'h00);
  endtask
  // Receiver stalls until the buffer refuses, then drains it
  task automatic scLink();
    wr(ADDR_MON_CTRL, 8'h00);
    wr(ADDR_PER_B0, 8'h1e);
    wr(ADDR_CTRL_BITS, 8'h05);
    wr(ADDR_LINK_EN_A, 8'h01);
    wr(ADDR_LINK_EN_B, 8'h02);
    stall <= 1'b1;
    wr(ADDR_MON_CTRL, 8'h02);
    repeat (32) put(32'h0000_0010, 4'h0);
    chk(sampleReady, 1'b0);
    @(posedge clock);
    stall <= 1'b0;
    repeat (28) put(32'h0000_0010, 4'h0);
    drain();
    chk(frame, {1'b1, 4'h0, 1'b1, 4'h0, 1'b1, 4'h2, 1'b1, 4'h0, 1'b1, 4'h0});
    chk(frameOk, 1'b1);
    chk(nWords, nSent);
  endtask
  // Three control bits, monitor off the top: top and low bits carry overrange
  task automatic scCtrl();
    wr(ADDR_CTRL_BITS, 8'h03);
    put(32'h0000_0050, 4'h0);
    chk(fd, 4'h1);
    @(posedge clock);
    stall <= 1'b1;
    put(32'h4040_4040, 4'h1);
    chk(linkValid, 1'b1);
    chk(linkData, 32'h4040_4047);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    sys_rst = 1'b1;
    sampleValid = 1'b0;
    sampleIn = '0;
    overrangeIn = '0;
    spiCsN = 1'b1;
    spiSclk = 1'b0;
    spiSdi = 1'b0;
    stall = 1'b0;
    rd = '0;
    nSent = 0;
    nMismatch = 0;
    checked = 0;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    scRegs();
    scFast();
    scPeak();
    scLink();
    scCtrl();
    results();
  end
endmodule
